// ### rtl/vsr_consts.svh
/*
 constants for the sequencer and feature-control register bank.
 assumes it is included by the package and by every design file.
*/
// Functional notes
// - feature bit3 ORs vsync with display enable
// - feature bits 1:0 store and read back
// - index 0-4 at 3C4 selects 3C5 register
// - reset bit1 low halts sequencer synchronously
// - reset bit0 low halts sequencer immediately
// - screen-off blanks video, syncs keep running
// - bit4 loads serializers every fourth character
// - bit3 divides dot clock by two
// - bit2 loads serializers every other character
// - bit0 zero gives nine-dot character clock
// - map mask bits enable planes 0-3; chain-4 here ignores the mask
// - font map A slot from bits 5,3,2
// - font map B slot from bits 4,1,0
// - plane 2/3 from extended select and attribute
// - chain-4 selects plane from low address bits
// - odd/even maps even/odd to plane pairs
// - extended memory bit enables beyond 64 KB
// - feature write port at 3BA or 3DA
`ifndef VSR_CONSTS_SVH
`define VSR_CONSTS_SVH
`define VSR_PORT_INDEX 16'h03C4
`define VSR_PORT_DATA 16'h03C5
`define VSR_PORT_FEAT_RD 16'h03CA
`define VSR_PORT_FEAT_WR_MONO 16'h03BA
`define VSR_PORT_FEAT_WR_COLOR 16'h03DA
`define VSR_IDX_RESET 3'h0
`define VSR_IDX_CLOCK 3'h1
`define VSR_IDX_MASK 3'h2
`define VSR_IDX_FONT 3'h3
`define VSR_IDX_MEM 3'h4
`define VSR_IDX_WMASK 8'h07
`define VSR_RESET_WMASK 8'h03
`define VSR_CLOCK_WMASK 8'h3D
`define VSR_MASK_WMASK 8'h0F
`define VSR_FONT_WMASK 8'h3F
`define VSR_MEM_WMASK 8'h0E
`define VSR_FEAT_WMASK 8'h0B
`define VSR_IDX_INIT 8'h00
`define VSR_RESET_INIT 8'h03
`define VSR_CLOCK_INIT 8'h00
`define VSR_MASK_INIT 8'h0F
`define VSR_FONT_INIT 8'h00
`define VSR_MEM_INIT 8'h00
`define VSR_FEAT_INIT 8'h00
`define VSR_RST_SYNC_BIT 1
`define VSR_RST_ASYNC_BIT 0
`define VSR_CLK_DOT8_BIT 0
`define VSR_CLK_LOAD2_BIT 2
`define VSR_CLK_DIV2_BIT 3
`define VSR_CLK_LOAD4_BIT 4
`define VSR_CLK_OFF_BIT 5
`define VSR_MEM_EXT_BIT 1
`define VSR_MEM_OE_BIT 2
`define VSR_MEM_CHAIN4_BIT 3
`define VSR_FEAT_VSYNC_OR_BIT 3
`define VSR_EVS_FONT_LO_BIT 2
`define VSR_EVS_FONT_HI_BIT 5
`define VSR_DOTS_NINE 4'h9
`define VSR_DOTS_EIGHT 4'h8
`define VSR_BUS_IDLE 8'h00
`endif

// ### rtl/vsr_pkg.sv
`include "vsr_consts.svh"
package vsr_pkg;
   typedef logic [7:0] vsr_byte_t;
   typedef enum logic [1:0] {VSR_RUN, VSR_SYNC_HALT, VSR_ASYNC_HALT} vsr_seq_e;
endpackage

// ### rtl/vsr_char_timer.sv
/*
 character clock and serializer load timing on the dot clock.
 assumes halt inputs come from flops on the same clock.
*/
`timescale 1ns/10ps
`include "vsr_consts.svh"
module vsr_char_timer import vsr_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic halt,
   input wire logic dot8,
   input wire logic div2,
   input wire logic load2,
   input wire logic load4,
   output logic dot_en,
   output logic char_tick,
   output logic load_tick
);
   logic half_q, half_d;
   logic [3:0] dot_q, dot_d;
   logic [1:0] chr_q, chr_d;
   logic [3:0] width;
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      width = dot8 ? `VSR_DOTS_EIGHT : `VSR_DOTS_NINE;
      dot_en = !halt && (!div2 || half_q);
      half_d = halt ? 1'b0 : ~half_q;
      dot_d = dot_q;
      chr_d = chr_q;
      // at or past the end, so a width change mid-character cannot overrun
      char_tick = dot_en && (dot_q >= width - 4'h1);
      if (halt) begin
         dot_d = 4'h0;
         chr_d = 2'h0;
      end else if (char_tick) begin
         dot_d = 4'h0;
         chr_d = chr_q + 2'h1;
      end else if (dot_en) begin
         dot_d = dot_q + 4'h1;
      end
      // bit4 has priority: a four-character fetch covers the other-character case
      if (load4) begin
         load_tick = char_tick && (chr_q == 2'h3);
      end else if (load2) begin
         load_tick = char_tick && chr_q[0];
      end else begin
         load_tick = char_tick;
      end
   end
   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         half_q <= 1'b0;
         dot_q <= 4'h0;
         chr_q <= 2'h0;
      end else begin
         half_q <= half_d;
         dot_q <= dot_d;
         chr_q <= chr_d;
      end
   end
endmodule

// ### rtl/vsr_plane_sel.sv
/*
 plane enables for processor accesses and font slot selection.
 purely combinational; callers register what they need.
*/
`timescale 1ns/10ps
`include "vsr_consts.svh"
module vsr_plane_sel import vsr_pkg::*; (
   input wire logic [3:0] map_mask,
   input wire logic chain4,
   input wire logic seq_mode,
   input wire logic [1:0] addr_low,
   input wire logic [5:0] font_sel,
   input wire logic [7:0] ext_sel,
   input wire logic attr_bit4,
   output logic [3:0] plane_en,
   output logic [2:0] font_slot,
   output logic font_plane3
);
   logic [2:0] map_n;
   always_comb begin
      plane_en = map_mask;
      if (chain4) begin
         plane_en = 4'h1 << addr_low;
      end else if (!seq_mode) begin
         plane_en = map_mask & (addr_low[0] ? 4'hA : 4'h5);
      end
      // attribute bit4 picks map A (1) or map B (0)
      map_n = attr_bit4 ? {font_sel[5], font_sel[3:2]} : {font_sel[4], font_sel[1:0]};
      font_slot = {map_n[1:0], map_n[2]};
      // plane 3 only when the extended select enables it for this map
      font_plane3 = attr_bit4 ? ext_sel[`VSR_EVS_FONT_HI_BIT]
                              : ext_sel[`VSR_EVS_FONT_LO_BIT];
   end
endmodule

// ### rtl/vsr_regs.sv
/*
 sequencer register bank with feature control, reached over the
 i/o port bus (port address, read and write strobes, byte data).
 also derives the character timing, the plane enables for host
 accesses, the font slot and the sync and pixel outputs.
 assumes strobes are synchronous to core_clk, one cycle per access;
 the sync inputs come from pins and are double-flopped here.
 colour emulation, the extended video select and the memory address
 bits come from logic on core_clk and are used without flops.
*/
`timescale 1ns/10ps
`include "vsr_consts.svh"
module vsr_regs import vsr_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_wdata,
   output logic [7:0] io_rdata,
   output logic io_hit,
   input wire logic color_emul,
   input wire logic [7:0] extended_video_select_reg,
   input wire logic video_mem_addr_bit_low,
   input wire logic video_mem_addr_bit_next,
   input wire logic attr_bit4,
   input wire logic vsync_in,
   input wire logic vde_in,
   input wire logic [3:0] pixel_in,
   output logic vsync_out,
   output logic [3:0] pixel_out,
   output logic seq_halted,
   output logic dot_en,
   output logic char_tick,
   output logic load_tick,
   output logic fetch32,
   output logic [3:0] plane_en,
   output logic [2:0] font_slot,
   output logic font_plane3,
   output logic ext_mem_en
);
   vsr_byte_t idx_q, idx_d;
   vsr_byte_t rst_q, rst_d;
   vsr_byte_t clk_q, clk_d;
   vsr_byte_t mask_q, mask_d;
   vsr_byte_t font_q, font_d;
   vsr_byte_t mem_q, mem_d;
   vsr_byte_t feat_q, feat_d;
   vsr_byte_t rdata_q, rdata_d;
   vsr_seq_e seq_q, seq_d;
   logic [1:0] vs_s1_q, vs_s2_q;
   logic [3:0] px_s1_q, px_s2_q;
   logic vsync_q, vsync_d;
   logic [3:0] pix_q, pix_d;
   logic wr_idx, wr_data, wr_feat, rd_idx, rd_data, rd_feat, halt;
   logic [15:0] feat_wr_port;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   // full sixteen-bit decode: aliases of other blocks must not hit
   always_comb begin
      feat_wr_port = color_emul ? `VSR_PORT_FEAT_WR_COLOR : `VSR_PORT_FEAT_WR_MONO;
      wr_idx = io_wr && (io_addr == `VSR_PORT_INDEX);
      wr_data = io_wr && (io_addr == `VSR_PORT_DATA);
      wr_feat = io_wr && (io_addr == feat_wr_port);
   end

   // ----------------------------------------
   // read decode
   // ----------------------------------------
   // the feature register reads at one port in both emulations
   always_comb begin
      rd_idx = io_rd && (io_addr == `VSR_PORT_INDEX);
      rd_data = io_rd && (io_addr == `VSR_PORT_DATA);
      rd_feat = io_rd && (io_addr == `VSR_PORT_FEAT_RD);
      io_hit = wr_idx || wr_data || wr_feat || rd_idx || rd_data || rd_feat;
   end

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   // reserved bits are masked off so they always read as zero
   always_comb begin
      idx_d = idx_q;
      rst_d = rst_q;
      clk_d = clk_q;
      mask_d = mask_q;
      font_d = font_q;
      mem_d = mem_q;
      feat_d = feat_q;
      if (wr_idx) begin
         idx_d = io_wdata & `VSR_IDX_WMASK;
      end
      if (wr_feat) begin
         feat_d = io_wdata & `VSR_FEAT_WMASK;
      end
      if (wr_data) begin
         unique case (idx_q[2:0])
            `VSR_IDX_RESET: rst_d = io_wdata & `VSR_RESET_WMASK;
            `VSR_IDX_CLOCK: clk_d = io_wdata & `VSR_CLOCK_WMASK;
            `VSR_IDX_MASK: mask_d = io_wdata & `VSR_MASK_WMASK;
            `VSR_IDX_FONT: font_d = io_wdata & `VSR_FONT_WMASK;
            `VSR_IDX_MEM: mem_d = io_wdata & `VSR_MEM_WMASK;
            // indexes 5-7 are unmapped: writes are dropped
            default: ;
         endcase
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   always_comb begin
      rdata_d = rdata_q;
      if (rd_idx) begin
         rdata_d = idx_q;
      end else if (rd_feat) begin
         rdata_d = feat_q;
      end else if (rd_data) begin
         unique case (idx_q[2:0])
            `VSR_IDX_RESET: rdata_d = rst_q;
            `VSR_IDX_CLOCK: rdata_d = clk_q;
            `VSR_IDX_MASK: rdata_d = mask_q;
            `VSR_IDX_FONT: rdata_d = font_q;
            `VSR_IDX_MEM: rdata_d = mem_q;
            default: rdata_d = `VSR_BUS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // sequencer run state
   // ----------------------------------------
   // the sync halt waits for the next character boundary so a
   // character is never cut; the async halt acts on the next edge
   always_comb begin
      seq_d = seq_q;
      unique case (seq_q)
         VSR_RUN: begin
            if (!rst_q[`VSR_RST_ASYNC_BIT]) begin
               seq_d = VSR_ASYNC_HALT;
            end else if (!rst_q[`VSR_RST_SYNC_BIT] && char_tick) begin
               seq_d = VSR_SYNC_HALT;
            end
         end
         VSR_SYNC_HALT, VSR_ASYNC_HALT: begin
            if (rst_q[`VSR_RST_ASYNC_BIT] && rst_q[`VSR_RST_SYNC_BIT]) begin
               seq_d = VSR_RUN;
            end
         end
      endcase
   end

   // ----------------------------------------
   // halt
   // ----------------------------------------
   // async clear does not wait for the state to move
   always_comb begin
      halt = (seq_q != VSR_RUN) || !rst_q[`VSR_RST_ASYNC_BIT];
      seq_halted = halt;
   end

   // ----------------------------------------
   // video outputs
   // ----------------------------------------
   always_comb begin
      if (feat_q[`VSR_FEAT_VSYNC_OR_BIT]) begin
         vsync_d = vs_s2_q[1] | vs_s2_q[0];
      end else begin
         vsync_d = vs_s2_q[1];
      end
      // screen off and halt blank pixels; sync is left untouched
      if (clk_q[`VSR_CLK_OFF_BIT] || halt) begin
         pix_d = 4'h0;
      end else begin
         pix_d = px_s2_q[3:0];
      end
   end

   // ----------------------------------------
   // host register state
   // ----------------------------------------
   // a sequencer halt leaves the bank alone; only rst_n reloads it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_q <= `VSR_IDX_INIT;
         rst_q <= `VSR_RESET_INIT;
         clk_q <= `VSR_CLOCK_INIT;
         mask_q <= `VSR_MASK_INIT;
         font_q <= `VSR_FONT_INIT;
         mem_q <= `VSR_MEM_INIT;
         feat_q <= `VSR_FEAT_INIT;
      end else begin
         idx_q <= idx_d;
         rst_q <= rst_d;
         clk_q <= clk_d;
         mask_q <= mask_d;
         font_q <= font_d;
         mem_q <= mem_d;
         feat_q <= feat_d;
      end
   end

   // ----------------------------------------
   // read data register
   // ----------------------------------------
   // held between reads so the host may fetch it late
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= `VSR_BUS_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ----------------------------------------
   // sequencer state register
   // ----------------------------------------
   // register writes move the state only through the reset register; rst_n forces run
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq_q <= VSR_RUN;
      end else begin
         seq_q <= seq_d;
      end
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // sync, display enable and pixels come from pins: two flops each,
   // bought with two cycles of lag on the video outputs
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vs_s1_q <= 2'h0;
         vs_s2_q <= 2'h0;
         px_s1_q <= 4'h0;
         px_s2_q <= 4'h0;
      end else begin
         vs_s1_q <= {vsync_in, vde_in};
         vs_s2_q <= vs_s1_q;
         px_s1_q <= pixel_in;
         px_s2_q <= px_s1_q;
      end
   end

   // ----------------------------------------
   // video output registers
   // ----------------------------------------
   // registered so the pins never show decode glitches
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vsync_q <= 1'b0;
         pix_q <= 4'h0;
      end else begin
         vsync_q <= vsync_d;
         pix_q <= pix_d;
      end
   end

   // ----------------------------------------
   // output ports
   // ----------------------------------------
   assign io_rdata = rdata_q;
   assign vsync_out = vsync_q;
   assign pixel_out = pix_q;
   assign fetch32 = clk_q[`VSR_CLK_LOAD4_BIT];
   assign ext_mem_en = mem_q[`VSR_MEM_EXT_BIT];

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   // character clock and serializer load pacing
   vsr_char_timer u_timer (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .halt(halt),
      .dot8(clk_q[`VSR_CLK_DOT8_BIT]),
      .div2(clk_q[`VSR_CLK_DIV2_BIT]),
      .load2(clk_q[`VSR_CLK_LOAD2_BIT]),
      .load4(clk_q[`VSR_CLK_LOAD4_BIT]),
      .dot_en(dot_en),
      .char_tick(char_tick),
      .load_tick(load_tick)
   );

   // plane enables and font slot, all combinational
   vsr_plane_sel u_plane (
      .map_mask(mask_q[3:0]),
      .chain4(mem_q[`VSR_MEM_CHAIN4_BIT]),
      .seq_mode(mem_q[`VSR_MEM_OE_BIT]),
      .addr_low({video_mem_addr_bit_next, video_mem_addr_bit_low}),
      .font_sel(font_q[5:0]),
      .ext_sel(extended_video_select_reg),
      .attr_bit4(attr_bit4),
      .plane_en(plane_en),
      .font_slot(font_slot),
      .font_plane3(font_plane3)
   );
endmodule

// ### test/vsr_regs_props.sv
/*
 port checker for the sequencer register bank.
 assumes a bind onto vsr_regs; one clock domain.
*/
`timescale 1ns/10ps
module vsr_regs_props (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [15:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_rdata,
   input wire logic io_hit,
   input wire logic color_emul,
   input wire logic [3:0] pixel_out,
   input wire logic seq_halted,
   input wire logic dot_en,
   input wire logic char_tick,
   input wire logic load_tick
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);
   // dots in the current character; a halt restarts it
   logic [3:0] dots_q;
   logic [3:0] dots_d;
   always_comb begin
      dots_d = dots_q;
      if (seq_halted || char_tick) begin
         dots_d = 4'h0;
      end else if (dot_en) begin
         dots_d = dots_q + 4'h1;
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dots_q <= 4'h0;
      end else begin
         dots_q <= dots_d;
      end
   end
   sequence acc_s;
      io_wr || io_rd;
   endsequence
   sequence feat_wr_s(port);
      io_wr && color_emul && io_addr == port;
   endsequence
   unmapped_ignore_a: assert property (acc_s ##0 io_addr[15:8] != 8'h03 |-> !io_hit)
      else $error("hit on unmapped port");
   index_port_a: assert property (acc_s ##0 io_addr == 16'h03C4 |-> io_hit)
      else $error("index port not decoded");
   feat_color_a: assert property (feat_wr_s(16'h03DA) |-> io_hit)
      else $error("feature write missed in colour mode");
   feat_mono_off_a: assert property (feat_wr_s(16'h03BA) |-> !io_hit)
      else $error("mono feature port decoded in colour mode");
   feat_mono_a: assert property (io_wr && !color_emul && io_addr == 16'h03BA |-> io_hit)
      else $error("mono feature port missed in mono mode");
   rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
      else $error("read data moved without a read");
   rdata_reset_a: assert property ($rose(rst_n) |-> io_rdata == 8'h00)
      else $error("read data not clear after reset");
   halt_blank_a: assert property (seq_halted |=> pixel_out == 4'h0)
      else $error("pixels pass while halted");
   halt_quiet_a: assert property (seq_halted |-> !char_tick && !load_tick)
      else $error("ticks while halted");
   load_on_char_a: assert property (load_tick |-> char_tick)
      else $error("load off character boundary");
   char_width_a: assert property (char_tick |-> dot_en && dots_q inside {4'h7, 4'h8})
      else $error("character not 8 or 9 dots");
endmodule

// ### test/vsr_host_model.sv
/*
 host processor model on the i/o port bus.
 assumes one-cycle strobes taken on rising core_clk.
*/
`timescale 1ns/10ps
module vsr_host_model (
   input wire logic core_clk,
   input wire logic [7:0] io_rdata,
   input wire logic io_hit,
   output logic [15:0] io_addr,
   output logic io_wr,
   output logic io_rd,
   output logic [7:0] io_wdata
);
   logic hit_seen = 1'b0;
   initial begin
      io_addr = 16'h0000;
      io_wr = 1'b0;
      io_rd = 1'b0;
      io_wdata = 8'h00;
   end
   // idle bus shows inverted values so stale data never looks valid
   task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d);
      @(posedge core_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= w;
      io_rd <= !w;
      @(posedge core_clk);
      hit_seen = io_hit;
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_addr <= ~a;
      io_wdata <= ~d;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      acc(a, 1'b1, d);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      acc(a, 1'b0, 8'h00);
      @(posedge core_clk);
      d = io_rdata;
   endtask
endmodule

// ### test/tb_top.sv
/*
 self-checking bench for the sequencer register bank.
 assumes the host model owns the port bus; pins are driven here.
*/
`timescale 1ns/10ps
module tb_top;
   typedef struct packed {
      logic [15:0] wp;
      logic [15:0] rp;
      logic [7:0] idx;
      logic [7:0] wd;
      logic [7:0] ex;
   } vsr_row_s;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic color_emul = 1'b1;
   logic [7:0] evs = 8'h20;
   logic [1:0] ma = 2'b00;
   logic attr4 = 1'b0;
   logic vs = 1'b0;
   logic vde = 1'b0;
   logic [3:0] pix = 4'hF;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata, v;
   logic [3:0] pixel_out, plane_en;
   logic [2:0] font_slot;
   logic io_wr, io_rd, io_hit, vsync_out, seq_halted, dot_en, char_tick, load_tick;
   logic fetch32, font_plane3, ext_mem_en;
   int n;
   int fails = 0;
   int total_checks = 0;
   vsr_row_s rows [8] = '{'{16'h03C5, 16'h03C5, 8'h00, 8'hFF, 8'h03},
      '{16'h03C5, 16'h03C5, 8'h01, 8'hFC, 8'h3C}, '{16'h03C5, 16'h03C5, 8'h02, 8'hFF, 8'h0F},
      '{16'h03C5, 16'h03C5, 8'h03, 8'hFF, 8'h3F}, '{16'h03C5, 16'h03C5, 8'h04, 8'hFF, 8'h0E},
      '{16'h03C5, 16'h03C5, 8'h05, 8'hFF, 8'h00}, '{16'h03DA, 16'h03CA, 8'h00, 8'hFF, 8'h0B},
      '{16'h03BA, 16'h03CA, 8'h00, 8'h00, 8'h0B}};
   logic [7:0] cm [5] = '{8'h01, 8'h00, 8'h09, 8'h05, 8'h11};
   int cc [5] = '{8, 9, 16, 8, 8};
   int lc [5] = '{8, 9, 16, 16, 32};
   logic [7:0] rv [5] = '{8'h03, 8'h00, 8'h0F, 8'h00, 8'h00};
   always #10 core_clk = ~core_clk;
   vsr_host_model host (.core_clk(core_clk), .io_rdata(io_rdata), .io_hit(io_hit),
      .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
   vsr_regs dut (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr),
      .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_hit(io_hit),
      .color_emul(color_emul), .extended_video_select_reg(evs),
      .video_mem_addr_bit_low(ma[0]), .video_mem_addr_bit_next(ma[1]), .attr_bit4(attr4),
      .vsync_in(vs), .vde_in(vde), .pixel_in(pix), .vsync_out(vsync_out),
      .pixel_out(pixel_out), .seq_halted(seq_halted), .dot_en(dot_en),
      .char_tick(char_tick), .load_tick(load_tick), .fetch32(fetch32), .plane_en(plane_en),
      .font_slot(font_slot), .font_plane3(font_plane3), .ext_mem_en(ext_mem_en));
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic sq_wr(input logic [7:0] idx, input logic [7:0] d);
      host.wr(16'h03C4, idx);
      host.wr(16'h03C5, d);
   endtask
   // cycles between two ticks; bounded so a dead timer cannot hang
   task automatic gap(input logic ld, output int c);
      int k;
      int t;
      k = 0;
      t = 0;
      c = 0;
      while (k < 2 && t < 400) begin
         @(posedge core_clk);
         t++;
         if (ld ? load_tick : char_tick) begin
            k++;
         end
         if (k == 1) begin
            c++;
         end
      end
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (rows[i]) begin
         host.wr(16'h03C4, rows[i].idx);
         host.rd(16'h03C4, v);
         chk("index", rows[i].idx, v);
         host.wr(rows[i].wp, rows[i].wd);
         host.rd(rows[i].rp, v);
         chk("reg", rows[i].ex, v);
      end
      host.wr(16'h03C6, 8'h55);
      chk("hit", 8'h00, {7'h00, host.hit_seen});
      host.wr(16'h13C4, 8'h07);
      chk("hit alias", 8'h00, {7'h00, host.hit_seen});
      host.rd(16'h03C4, v);
      chk("index alias", 8'h00, v);
      for (int i = 0; i < 5; i++) begin
         sq_wr(8'h00, 8'h01);
         n = 0;
         while (!seq_halted && n < 40) begin
            @(posedge core_clk);
            n++;
         end
         chk("sync halt", 8'h01, {7'h00, seq_halted});
         sq_wr(8'h01, cm[i]);
         sq_wr(8'h00, 8'h03);
         gap(1'b0, n);
         chk("char gap", 8'(cc[i]), 8'(n));
         gap(1'b1, n);
         chk("load gap", 8'(lc[i]), 8'(n));
         chk("fetch32", {7'h00, cm[i][4]}, {7'h00, fetch32});
      end
      sq_wr(8'h00, 8'h02);
      @(negedge core_clk);
      chk("async halt", 8'h01, {7'h00, seq_halted});
      repeat (5) @(posedge core_clk);
      chk("pixel halted", 8'h00, {4'h0, pixel_out});
      sq_wr(8'h00, 8'h03);
      repeat (5) @(posedge core_clk);
      chk("pixel", 8'h0F, {4'h0, pixel_out});
      sq_wr(8'h01, 8'h20);
      vs <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk("blank", 8'h00, {4'h0, pixel_out});
      chk("sync on", 8'h01, {7'h00, vsync_out});
      vs <= 1'b0;
      vde <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk("vsync or", 8'h01, {7'h00, vsync_out});
      host.wr(16'h03DA, 8'h00);
      repeat (5) @(posedge core_clk);
      chk("vsync", 8'h00, {7'h00, vsync_out});
      vs <= 1'b1;
      repeat (5) @(posedge core_clk);
      chk("vsync pass", 8'h01, {7'h00, vsync_out});
      vs <= 1'b0;
      color_emul <= 1'b0;
      host.wr(16'h03DA, 8'h08);
      host.wr(16'h03BA, 8'h01);
      host.rd(16'h03CA, v);
      chk("feat mono", 8'h01, v);
      color_emul <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         v = 8'(i);
         sq_wr(8'h03, {2'b00, v[2], ~v[2], v[1:0], ~v[1:0]});
         attr4 <= 1'b1;
         @(negedge core_clk);
         chk("font a", {5'h00, v[1:0], v[2]}, {5'h00, font_slot});
         chk("plane a", 8'h01, {7'h00, font_plane3});
         @(posedge core_clk);
         attr4 <= 1'b0;
         @(negedge core_clk);
         chk("font b", {5'h00, ~v[1:0], ~v[2]}, {5'h00, font_slot});
         chk("plane b", 8'h00, {7'h00, font_plane3});
      end
      sq_wr(8'h02, 8'h0F);
      sq_wr(8'h04, 8'h08);
      for (int a = 0; a < 4; a++) begin
         ma <= 2'(a);
         @(negedge core_clk);
         chk("chain4", 8'(1 << a), {4'h0, plane_en});
         @(posedge core_clk);
      end
      sq_wr(8'h04, 8'h00);
      ma <= 2'b01;
      @(negedge core_clk);
      chk("odd", 8'h0A, {4'h0, plane_en});
      @(posedge core_clk);
      ma <= 2'b10;
      @(negedge core_clk);
      chk("even", 8'h05, {4'h0, plane_en});
      sq_wr(8'h02, 8'h06);
      sq_wr(8'h04, 8'h06);
      @(negedge core_clk);
      chk("mask", 8'h06, {4'h0, plane_en});
      chk("ext mem", 8'h01, {7'h00, ext_mem_en});
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      host.rd(16'h03C4, v);
      chk("index rst", 8'h00, v);
      host.rd(16'h03CA, v);
      chk("feat rst", 8'h00, v);
      chk("ext mem rst", 8'h00, {7'h00, ext_mem_en});
      foreach (rv[i]) begin
         host.wr(16'h03C4, 8'(i));
         host.rd(16'h03C5, v);
         chk("reset val", rv[i], v);
      end
      test_done();
   end
   // tests take well under 1000 cycles; the 30000-cycle limit cuts a hang
   initial begin
      #600000;
      fails++;
      test_done();
   end
endmodule
bind vsr_regs vsr_regs_props props (.core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr),
   .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .io_hit(io_hit),
   .color_emul(color_emul), .pixel_out(pixel_out), .seq_halted(seq_halted),
   .dot_en(dot_en), .char_tick(char_tick), .load_tick(load_tick));
